// ---- rwl_pkg.sv ----
// Purpose: shared constants and types for the reset, watchdog and low-power control block
// Assumes: one 50 MHz clock standing in for the oscillator; the phase clock is a gated enable
// Notes:   all counts are in oscillator-clock cycles
package rwl_pkg;

  localparam logic [12:0] RWL_WDOG_CLR_ADDR = 13'h1ff0;  // watchdog clear / vector byte
  localparam int          RWL_WDOG_CLR_BIT  = 0;         // write 0 here clears the watchdog
  localparam int          RWL_STAB_CYCLES   = 4064;      // oscillator stabilization delay
  localparam int          RWL_WDOG_STAGES   = 18;        // watchdog ripple stages
  localparam logic [7:0]  RWL_VECTOR_MSB    = 8'h00;     // unimplemented vector byte, arbitrary
  localparam logic [2:0]  RWL_SYNC_RST      = 3'h0;      // pin synchroniser reset value

  // low-power state of the core
  typedef enum logic [2:0] {
    RWL_RUN   = 3'b000,
    RWL_STOP  = 3'b001,
    RWL_HALT  = 3'b010,
    RWL_WAIT  = 3'b011,
    RWL_STAB  = 3'b100
  } rwl_mode_e;

  // operating mode latched at reset release
  typedef struct packed {
    logic test_mode;  // interrupt pin at test level at release
    logic capture;    // capture pin level at release
  } rwl_opmode_s;

  // whole state of the block
  typedef struct packed {
    logic [2:0]  rst_sync;   // external reset pin synchroniser
    logic [2:0]  irq_sync;   // interrupt pin synchroniser
    logic [2:0]  tst_sync;   // test-level detector synchroniser
    logic [2:0]  cap_sync;   // capture pin synchroniser
    logic        por_done;   // power-on delay finished
    logic [11:0] stab_cnt;   // free-running stabilization timer
    logic [17:0] wdog_cnt;   // watchdog ripple counter
    logic        wdog_rst;   // watchdog timeout pending
    logic        rst_reg;    // internal reset, registered on every clock
    logic        ext_was;    // external reset seen last cycle
    rwl_opmode_s opmode;     // latched operating mode
    rwl_mode_e   mode;       // low-power state
    logic        phase_en;   // phase clock enable
    logic        osc_en;     // oscillator enable
    logic [7:0]  rdata;      // register read data
  } rwl_state_s;

endpackage : rwl_pkg

// ---- rwl_ctrl.sv ----
// Purpose: reset generation, watchdog and low-power mode sequencing
// Assumes: clk is the oscillator; the phase clock is modelled as phase_clk_en
// Notes:
module rwl_ctrl
  import rwl_pkg::*;
#(
  parameter int STAB_CYCLES = RWL_STAB_CYCLES,
  parameter int WDOG_STAGES = RWL_WDOG_STAGES
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ext_reset_pin_b,
  input  wire logic        irq_pin_b,
  input  wire logic        irq_test_level,
  input  wire logic        capture_input_pin,
  input  wire logic        wdog_option_en,
  input  wire logic        stop_conv_option,
  input  wire logic        stop_exec,
  input  wire logic        wait_exec,
  input  wire logic        timer_irq,
  input  wire logic [12:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [7:0]  rdata,
  output logic             internal_rst,
  output logic             phase_clk_en,
  output logic             osc_en,
  output logic             clear_irq_mask,
  output logic             test_mode,
  output logic             capture_mode,
  output logic      [2:0]  lp_mode
);

  localparam logic [11:0] STAB_LAST = 12'(STAB_CYCLES - 1);
  localparam logic [17:0] WDOG_LAST = 18'((1 << WDOG_STAGES) - 1);

  rwl_state_s st_reg;
  rwl_state_s st_next;

  // filtered pin levels: irq_low and tst_hi assert only while second and third stages agree; ext_low flips while they differ; cap_hi takes stage three alone
  logic ext_low;
  logic irq_low;
  logic tst_hi;
  logic cap_hi;
  logic wdog_clr;
  logic lp_enter;
  logic any_rst;

  // returns stage three once stage two and three agree, otherwise prev
  function automatic logic agreed(input logic [2:0] s, input logic prev);
    agreed = (s[1] == s[2]) ? s[2] : prev;
  endfunction : agreed

  always_comb begin
    st_next  = st_reg;
    ext_low  = agreed(~st_reg.rst_sync, ~st_reg.ext_was);
    irq_low  = agreed(~st_reg.irq_sync, 1'b0);
    tst_hi   = agreed(st_reg.tst_sync, 1'b0);
    cap_hi   = st_reg.cap_sync[2];
    wdog_clr = wr_stb && addr == RWL_WDOG_CLR_ADDR
               && !wdata[RWL_WDOG_CLR_BIT];
    lp_enter = 1'b0;

    // three-stage pin synchronisers
    st_next.rst_sync = {st_reg.rst_sync[1:0], ext_reset_pin_b};
    st_next.irq_sync = {st_reg.irq_sync[1:0], irq_pin_b};
    st_next.tst_sync = {st_reg.tst_sync[1:0], irq_test_level};
    st_next.cap_sync = {st_reg.cap_sync[1:0], capture_input_pin};
    st_next.ext_was  = ext_low;

    // free-running stabilization timer, halted with the oscillator
    if (st_reg.osc_en) begin
      st_next.stab_cnt = (st_reg.stab_cnt == STAB_LAST) ? 12'h000
                         : st_reg.stab_cnt + 12'h001;
    end

    // power-on delay counted once after oscillator start
    if (!st_reg.por_done && st_reg.stab_cnt == STAB_LAST) begin
      st_next.por_done = 1'b1;
    end

    // watchdog counter: runs with the oscillator, disabled at test level
    if (wdog_clr || st_reg.rst_reg) begin
      st_next.wdog_cnt = 18'h00000;
      if (st_reg.rst_reg) begin
        st_next.wdog_rst = 1'b0;
      end
    end else if (st_reg.osc_en && wdog_option_en && !tst_hi) begin
      st_next.wdog_cnt = st_reg.wdog_cnt + 18'h00001;
    end

    // timeout wins over a service write landing in the same cycle
    if (!st_reg.rst_reg && st_reg.osc_en && wdog_option_en && !tst_hi
        && st_reg.wdog_cnt == WDOG_LAST) begin
      st_next.wdog_rst = 1'b1;
    end

    // combined reset registered on every oscillator clock edge
    any_rst = ext_low || !st_reg.por_done || st_reg.wdog_rst;
    st_next.rst_reg = any_rst;

    // latch operating mode on external reset release
    if (st_reg.ext_was && !ext_low) begin
      st_next.opmode.test_mode = tst_hi;
      st_next.opmode.capture   = cap_hi;
    end

    // low-power sequencing; registers elsewhere are untouched while idle
    unique case (st_reg.mode)
      RWL_RUN: begin
        if (stop_exec && !stop_conv_option) begin
          st_next.mode     = RWL_STOP;
          st_next.osc_en   = 1'b0;
          st_next.phase_en = 1'b0;
          lp_enter         = 1'b1;
        end else if (stop_exec || wait_exec) begin
          st_next.mode     = stop_exec ? RWL_HALT : RWL_WAIT;
          st_next.phase_en = 1'b0;
          lp_enter         = 1'b1;
        end
      end
      RWL_STOP: begin
        if (irq_low || ext_low) begin
          st_next.mode     = RWL_STAB;
          st_next.osc_en   = 1'b1;
          st_next.stab_cnt = 12'h000;
        end
      end
      RWL_STAB: begin
        if (st_reg.stab_cnt == STAB_LAST) begin
          st_next.mode     = RWL_RUN;
          st_next.phase_en = 1'b1;
        end
      end
      RWL_HALT: begin
        if (irq_low || ext_low || timer_irq) begin
          st_next.mode = RWL_STAB;
        end
      end
      RWL_WAIT: begin
        if (irq_low || ext_low || timer_irq || st_reg.wdog_rst) begin
          st_next.mode     = RWL_RUN;
          st_next.phase_en = 1'b1;
        end
      end
      default: begin
        st_next.mode = RWL_RUN;
      end
    endcase

    // watchdog reset also wakes halt, and a full reset restarts the core except in stop and stabilization
    if (st_reg.rst_reg && st_reg.mode != RWL_STOP && st_reg.mode != RWL_STAB) begin
      st_next.mode     = RWL_RUN;
      st_next.phase_en = 1'b1;
    end

    // read path: vector byte only; state unchanged by reads
    st_next.rdata = (rd_stb && addr == RWL_WDOG_CLR_ADDR) ? RWL_VECTOR_MSB
                    : 8'h00;
  end

  // one register for all state; synchronous active-low reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_reg          <= '0;
      st_reg.rst_sync <= RWL_SYNC_RST;
      st_reg.osc_en   <= 1'b1;
      st_reg.phase_en <= 1'b1;
      st_reg.rst_reg  <= 1'b1;
      st_reg.mode     <= RWL_RUN;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs
  assign rdata          = st_reg.rdata;
  assign internal_rst   = st_reg.rst_reg;
  assign phase_clk_en   = st_reg.phase_en && !st_reg.rst_reg;
  assign osc_en         = st_reg.osc_en;
  assign clear_irq_mask = lp_enter;
  assign test_mode      = st_reg.opmode.test_mode;
  assign capture_mode   = st_reg.opmode.capture;
  assign lp_mode        = st_reg.mode;

endmodule : rwl_ctrl

// ---- rwl_ctrl_props.sv ----
// Purpose: checker for reset and low-power control
// Assumes: short stabilization count
// Notes:   sees only the block's ports
module rwl_ctrl_props
  import rwl_pkg::*;
#(
  parameter int STAB_CYCLES = RWL_STAB_CYCLES
) (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       ext_reset_pin_b,
  input wire logic       stop_exec,
  input wire logic       wait_exec,
  input wire logic       stop_conv_option,
  input wire logic       internal_rst,
  input wire logic       phase_clk_en,
  input wire logic       osc_en,
  input wire logic       clear_irq_mask,
  input wire logic [2:0] lp_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // reset, entry, gating and exit of low-power states
  pin_hold_a: assert property (!ext_reset_pin_b [*5] |=> internal_rst)
    else $error("pin low without reset");
  stop_in_a: assert property (
    stop_exec && phase_clk_en && !stop_conv_option |=> lp_mode == 3'h1 && !osc_en)
    else $error("stop not entered");
  halt_in_a: assert property (
    stop_exec && phase_clk_en && stop_conv_option |=> lp_mode == 3'h2 && osc_en)
    else $error("halt not entered");
  wait_in_a: assert property (wait_exec && phase_clk_en |=> lp_mode == 3'h3)
    else $error("wait not entered");
  mask_clr_a: assert property (
    (stop_exec || wait_exec) && phase_clk_en |-> clear_irq_mask)
    else $error("mask not cleared");
  lp_gate_a: assert property (lp_mode inside {3'h1, 3'h2, 3'h3} |-> !phase_clk_en)
    else $error("phase clock runs in low power");
  stop_stab_a: assert property (
    $past(lp_mode) == 3'h1 && lp_mode == 3'h4 |-> (lp_mode == 3'h4) [*8])
    else $error("stop exit too short");
  stab_end_a: assert property (lp_mode == 3'h4 |-> ##[1:40] lp_mode == 3'h0)
    else $error("stabilization too long");
endmodule : rwl_ctrl_props

bind rwl_ctrl rwl_ctrl_props #(.STAB_CYCLES(STAB_CYCLES)) props_u (.clk, .rst_b,
  .ext_reset_pin_b, .stop_exec, .wait_exec, .stop_conv_option, .internal_rst,
  .phase_clk_en, .osc_en, .clear_irq_mask, .lp_mode);

// ---- rwl_core_model.sv ----
// Purpose: core model issuing low-power instructions
// Assumes: core retires instructions only on a live phase clock
// Notes:   one-cycle pulses
module rwl_core_model (
  input  wire logic clk,
  input  wire logic do_stop,
  input  wire logic do_wait,
  input  wire logic phase_clk_en,
  output logic      stop_exec,
  output logic      wait_exec
);
  // a gated core cannot execute anything
  always_ff @(posedge clk) begin
    stop_exec <= do_stop & phase_clk_en;
    wait_exec <= do_wait & phase_clk_en;
  end
endmodule : rwl_core_model

// ---- tb_top.sv ----
// Purpose: bench for reset, watchdog and low-power control
// Assumes: short stabilization and watchdog counts
// Notes:   inputs move 1 ns after the rising edge
module tb_top
  import rwl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_b, ext_reset_pin_b, irq_pin_b, irq_test_level, capture_input_pin;
  logic        wdog_option_en, stop_conv_option, do_stop, do_wait, timer_irq, wr_stb, rd_stb;
  logic        stop_exec, wait_exec, internal_rst, phase_clk_en, osc_en, clear_irq_mask;
  logic        test_mode, capture_mode, seen;
  logic [12:0] addr;
  logic [7:0]  wdata, rdata;
  logic [2:0]  lp_mode;
  int          mismatches, check_count, n;
  rwl_ctrl #(.STAB_CYCLES(16), .WDOG_STAGES(6)) dut_u (.*);
  rwl_core_model core_u (.*);
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // sticky record of any internal reset
  always @(posedge clk) if (internal_rst) seen <= 1'b1;
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    addr <= a;
    rd_stb <= 1'b1;
    cyc(1);
    rd_stb <= 1'b0;
    chk("rdata", rdata, e);
    cyc(1);
  endtask : rd
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    cyc(1);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic lp(input logic s, input logic w);
    do_stop <= s;
    do_wait <= w;
    cyc(1);
    do_stop <= 1'b0;
    do_wait <= 1'b0;
    cyc(2);
  endtask : lp
  task automatic wt(input logic s, input logic [2:0] m);
    n = 0;
    while ((s ? {2'h0, internal_rst} : lp_mode) !== m && n < 300) begin
      cyc(1);
      n++;
    end
    chk("wait_done", n < 300, 1'b1);
  endtask : wt
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  // hang guard
  initial begin
    #60us;
    mismatches++;
    give_verdict();
  end
  // test sequence
  initial begin
    {rst_b, irq_test_level, capture_input_pin, wdog_option_en, stop_conv_option} = '0;
    {do_stop, do_wait, timer_irq, wr_stb, rd_stb, seen, addr, wdata} = '0;
    {ext_reset_pin_b, irq_pin_b, mismatches, check_count} = '0;
    {ext_reset_pin_b, irq_pin_b} = 2'h3;
    cyc(8);
    rst_b <= 1'b1;
    cyc(4);
    chk("por", internal_rst, 1'b1);
    wt(1'b1, 3'h0);
    chk("por_len", n >= 10, 1'b1);
    rd(RWL_WDOG_CLR_ADDR, RWL_VECTOR_MSB);
    rd(13'h1ff1, 8'h00);
    lp(1'b1, 1'b0);
    chk("stop", {osc_en, lp_mode}, 8'h01);
    irq_pin_b <= 1'b0;
    wt(1'b0, 3'h0);
    irq_pin_b <= 1'b1;
    chk("stop_len", n >= 16, 1'b1);
    stop_conv_option <= 1'b1;
    lp(1'b1, 1'b0);
    chk("halt", {osc_en, phase_clk_en, lp_mode}, 8'h12);
    timer_irq <= 1'b1;
    wt(1'b0, 3'h0);
    timer_irq <= 1'b0;
    chk("halt_len", n <= 20, 1'b1);
    lp(1'b0, 1'b1);
    chk("wait", {osc_en, phase_clk_en, lp_mode}, 8'h13);
    irq_pin_b <= 1'b0;
    wt(1'b0, 3'h0);
    irq_pin_b <= 1'b1;
    capture_input_pin <= 1'b1;
    ext_reset_pin_b <= 1'b0;
    cyc(16);
    chk("ext_rst", internal_rst, 1'b1);
    ext_reset_pin_b <= 1'b1;
    wt(1'b1, 3'h0);
    chk("mode", {test_mode, capture_mode}, 8'h01);
    capture_input_pin <= 1'b0;
    wdog_option_en <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      seen = 1'b0;
      repeat (6) begin
        cyc(30);
        wr(i == 2 ? 13'h1ff1 : RWL_WDOG_CLR_ADDR, i == 1 ? 8'h01 : 8'h00);
      end
      chk("wdog", seen, i != 0);
      wt(1'b1, 3'h0);
    end
    chk("cap_kept", capture_mode, 1'b1);
    irq_test_level <= 1'b1;
    cyc(4);
    seen = 1'b0;
    cyc(200);
    chk("tst_off", seen, 1'b0);
    irq_test_level <= 1'b0;
    cyc(150);
    chk("tst_back", seen, 1'b1);
    give_verdict();
  end
endmodule : tb_top
